// *** design/sbd_params.svh ***
// Summary of operation
// [RULE1] Register-minus-working computes memory register minus working register, 8-bit two's complement.
// [RULE2] Destination bit 0 sends the difference to working register; memory stays unchanged.
// [RULE3] Destination bit 1 writes the difference back to the source memory register.
// [RULE4] Access bit 0 resolves the address in the fixed access bank, bank select ignored.
// [RULE5] Access bit 1 takes the bank from the bank select register.
// [RULE6] Access bit 0 with extended set: addresses up to 95 become indexed offsets.
// [RULE7] Literal-minus-working puts literal minus working into working; carry means no borrow.
// [RULE8] Both run in one cycle and word; update negative, signed excess, carry, nibble carry, zero.
//
// Purpose: Register offsets, encodings and reset values of the subtract datapath.
// Assumes: Byte offsets on a 32-bit AHB-Lite bus, one register per word.
// Notes:   Definitions only.
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH

`define SBD_OFF_INSTR 8'h00
`define SBD_OFF_WREG 8'h04
`define SBD_OFF_BANK 8'h08
`define SBD_OFF_STATUS 8'h0c
`define SBD_OFF_CFG 8'h10
`define SBD_OFF_IDX 8'h14
`define SBD_OFF_MADDR 8'h18
`define SBD_OFF_MDATA 8'h1c

`define SBD_OPC_LIT 8'h08
`define SBD_OPC_RMW 6'h17
`define SBD_BIT_D 9
`define SBD_BIT_A 8

`define SBD_ACC_SPLIT 8'h60
`define SBD_ACC_LO_BANK 4'h0
`define SBD_ACC_HI_BANK 4'hf
`define SBD_IDX_LIMIT 8'h5f

`define SBD_W_RST 8'h00
`define SBD_BANK_RST 4'h0
`define SBD_FLAGS_RST 5'h00
`define SBD_CFG_RST 1'b0
`define SBD_IDX_RST 12'h000
`define SBD_INSTR_RST 16'h0000

`endif

// *** design/sbd_pkg.sv ***
// Purpose: Types shared by the subtract datapath modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   Flag struct order matches the status register layout.
package sbd_pkg;
    typedef enum logic [1:0] {
        SBD_OP_NONE = 2'b00,
        SBD_OP_LIT = 2'b01,
        SBD_OP_RMW = 2'b10
    } sbd_op_t;

    typedef enum logic [1:0] {
        SBD_BS_IDLE = 2'b00,
        SBD_BS_RWAIT = 2'b01,
        SBD_BS_RDONE = 2'b10
    } sbd_bus_st_t;

    typedef struct packed {
        logic n;
        logic signed_excess_flag;
        logic z;
        logic nibble_carry_flag;
        logic c;
    } sbd_flags_t;
endpackage : sbd_pkg

// *** design/sbd_alu_if.sv ***
// Purpose: Operand and result bundle between core and subtractor.
// Assumes: Purely combinational use.
// Notes:   None.
`timescale 1ns/10ps
interface sbd_alu_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic [7:0] diff;
    sbd_pkg::sbd_flags_t flags;
    modport alu (input minuend, input subtrahend, output diff, output flags);
    modport core (output minuend, output subtrahend, input diff, input flags);
endinterface : sbd_alu_if

// *** design/sbd_alu.sv ***
// Purpose: 8-bit subtractor with status flag generation.
// Assumes: Minuend minus subtrahend, borrow shown as carry low.
// Notes:   Combinational; the core registers the results.
`timescale 1ns/10ps
module sbd_alu (
    sbd_alu_if.alu p
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        // Add the inverted subtrahend plus one so carry out is the no-borrow flag
        full = {1'b0, p.minuend} + {1'b0, ~p.subtrahend} + 9'h001; // RULE1
        low = {1'b0, p.minuend[3:0]} + {1'b0, ~p.subtrahend[3:0]} + 5'h01;
        p.diff = full[7:0];
        p.flags.c = full[8]; // RULE7
        p.flags.nibble_carry_flag = low[4]; // RULE8
        p.flags.z = (full[7:0] == 8'h00); // RULE8
        p.flags.n = full[7]; // RULE8
        p.flags.signed_excess_flag = (p.minuend[7] != p.subtrahend[7])
            && (full[7] != p.minuend[7]); // RULE8
    end
endmodule : sbd_alu

// *** design/sbd_top.sv ***
// Purpose: Subtract instruction datapath with AHB-Lite register access.
// Assumes: A write to the instruction register executes it in that data phase.
// Notes:   Reads take one wait state so they see any write that completed just before.
`timescale 1ns/10ps
`include "sbd_params.svh"
module sbd_top #(
    parameter int MEM_AW = 10
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    if (MEM_AW < 8 || MEM_AW > 12) begin : g_chk
        $error("MEM_AW must lie between 8 and 12");
    end

    localparam int DEPTH = 1 << MEM_AW;

    logic [7:0] w_r, w_nxt;
    logic [3:0] bank_r, bank_nxt;
    sbd_pkg::sbd_flags_t flags_r, flags_nxt;
    logic ext_r, ext_nxt;
    logic [11:0] idx_r, idx_nxt;
    logic [11:0] maddr_r, maddr_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic [7:0] mem_r [DEPTH];
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    sbd_pkg::sbd_bus_st_t bs_r, bs_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_off_r, wr_off_nxt;
    logic [7:0] rd_off_r, rd_off_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;

    logic acc;
    logic wr_data;
    sbd_pkg::sbd_op_t exec_op;
    logic [7:0] ex_f, ex_k;
    logic ex_d, ex_a;
    logic [11:0] eff_addr;
    logic [MEM_AW-1:0] mem_idx;
    logic [7:0] mem_val;
    logic [7:0] alu_diff;
    logic [7:0] lit_expect;
    logic lit_nob;

    sbd_alu_if ai ();

    sbd_alu u_alu (
        .p(ai.alu)
    );

    function automatic logic [11:0] resolve_addr(
        input logic [7:0] f,
        input logic a,
        input logic [3:0] bank,
        input logic ext,
        input logic [11:0] idx
    );
        logic [11:0] r;
        if (a) begin
            r = {bank, f};
        end else if (ext && f <= `SBD_IDX_LIMIT) begin
            r = idx + {4'h0, f};
        end else if (f < `SBD_ACC_SPLIT) begin
            r = {`SBD_ACC_LO_BANK, f};
        end else begin
            r = {`SBD_ACC_HI_BANK, f};
        end
        return r;
    endfunction : resolve_addr

    // Bus slave: writes complete with no wait, reads with one
    always_comb begin
        acc = hsel && htrans[1] && hready;
        bs_nxt = bs_r;
        rd_off_nxt = rd_off_r;
        hrdata_nxt = hrdata_r;
        wr_pend_nxt = acc && hwrite;
        wr_off_nxt = acc ? haddr[7:0] : wr_off_r;
        unique case (bs_r)
            sbd_pkg::SBD_BS_IDLE, sbd_pkg::SBD_BS_RDONE: begin
                bs_nxt = sbd_pkg::SBD_BS_IDLE;
                if (acc && !hwrite) begin
                    bs_nxt = sbd_pkg::SBD_BS_RWAIT;
                    rd_off_nxt = haddr[7:0];
                end
            end
            sbd_pkg::SBD_BS_RWAIT: begin
                bs_nxt = sbd_pkg::SBD_BS_RDONE;
                case (rd_off_r)
                    `SBD_OFF_INSTR: hrdata_nxt = {16'h0000, instr_r};
                    `SBD_OFF_WREG: hrdata_nxt = {24'h000000, w_r};
                    `SBD_OFF_BANK: hrdata_nxt = {28'h0000000, bank_r};
                    `SBD_OFF_STATUS: hrdata_nxt = {27'h0, flags_r};
                    `SBD_OFF_CFG: hrdata_nxt = {31'h0, ext_r};
                    `SBD_OFF_IDX: hrdata_nxt = {20'h00000, idx_r};
                    `SBD_OFF_MADDR: hrdata_nxt = {20'h00000, maddr_r};
                    `SBD_OFF_MDATA: hrdata_nxt = {24'h000000, mem_r[maddr_r[MEM_AW-1:0]]};
                    default: hrdata_nxt = 32'h00000000;
                endcase
            end
            default: bs_nxt = sbd_pkg::SBD_BS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bs_r <= sbd_pkg::SBD_BS_IDLE;
            rd_off_r <= 8'h00;
            hrdata_r <= 32'h00000000;
            wr_pend_r <= 1'b0;
            wr_off_r <= 8'h00;
        end else begin
            bs_r <= bs_nxt;
            rd_off_r <= rd_off_nxt;
            hrdata_r <= hrdata_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_off_r <= wr_off_nxt;
        end
    end

    assign hreadyout = (bs_r != sbd_pkg::SBD_BS_RWAIT); // RULE8
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    // Kept out of the operand process so that process never reads its own result
    assign alu_diff = ai.diff;

    // Decode and execute in the instruction write's data phase
    always_comb begin
        wr_data = wr_pend_r;
        ex_f = hwdata[7:0];
        ex_k = hwdata[7:0];
        ex_d = hwdata[`SBD_BIT_D];
        ex_a = hwdata[`SBD_BIT_A];
        exec_op = sbd_pkg::SBD_OP_NONE;
        if (wr_data && wr_off_r == `SBD_OFF_INSTR) begin
            if (hwdata[15:8] == `SBD_OPC_LIT) begin
                exec_op = sbd_pkg::SBD_OP_LIT;
            end else if (hwdata[15:10] == `SBD_OPC_RMW) begin
                exec_op = sbd_pkg::SBD_OP_RMW;
            end
        end
        eff_addr = resolve_addr(ex_f, ex_a, bank_r, ext_r, idx_r); // RULE4 RULE5 RULE6
        mem_idx = eff_addr[MEM_AW-1:0];
        mem_val = mem_r[mem_idx];
        ai.minuend = (exec_op == sbd_pkg::SBD_OP_LIT) ? ex_k : mem_val; // RULE1 RULE7
        ai.subtrahend = w_r;
        lit_expect = ex_k - w_r;
        lit_nob = (ex_k >= w_r);
    end

    // Register file and data memory next values
    always_comb begin
        w_nxt = w_r;
        bank_nxt = bank_r;
        flags_nxt = flags_r;
        ext_nxt = ext_r;
        idx_nxt = idx_r;
        maddr_nxt = maddr_r;
        instr_nxt = instr_r;
        mem_we = 1'b0;
        mem_wa = mem_idx;
        mem_wd = alu_diff;
        if (exec_op != sbd_pkg::SBD_OP_NONE) begin
            flags_nxt = ai.flags; // RULE8
            if (exec_op == sbd_pkg::SBD_OP_LIT || !ex_d) begin
                w_nxt = alu_diff; // RULE2 RULE7
            end else begin
                mem_we = 1'b1; // RULE3
            end
        end
        if (wr_data) begin
            case (wr_off_r)
                `SBD_OFF_INSTR: instr_nxt = hwdata[15:0];
                `SBD_OFF_WREG: w_nxt = hwdata[7:0];
                `SBD_OFF_BANK: bank_nxt = hwdata[3:0];
                `SBD_OFF_STATUS: flags_nxt = hwdata[4:0];
                `SBD_OFF_CFG: ext_nxt = hwdata[0];
                `SBD_OFF_IDX: idx_nxt = hwdata[11:0];
                `SBD_OFF_MADDR: maddr_nxt = hwdata[11:0];
                `SBD_OFF_MDATA: begin
                    mem_we = 1'b1;
                    mem_wa = maddr_r[MEM_AW-1:0];
                    mem_wd = hwdata[7:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_r <= `SBD_W_RST;
            bank_r <= `SBD_BANK_RST;
            flags_r <= `SBD_FLAGS_RST;
            ext_r <= `SBD_CFG_RST;
            idx_r <= `SBD_IDX_RST;
            maddr_r <= `SBD_IDX_RST;
            instr_r <= `SBD_INSTR_RST;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else begin
            w_r <= w_nxt;
            bank_r <= bank_nxt;
            flags_r <= flags_nxt;
            ext_r <= ext_nxt;
            idx_r <= idx_nxt;
            maddr_r <= maddr_nxt;
            instr_r <= instr_nxt;
            if (mem_we) begin
                mem_r[mem_wa] <= mem_wd;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rmw_w;
        exec_op == sbd_pkg::SBD_OP_RMW && !ex_d;
    endsequence
    sequence s_rmw_f;
        exec_op == sbd_pkg::SBD_OP_RMW && ex_d;
    endsequence
    sequence s_access_direct;
        exec_op == sbd_pkg::SBD_OP_RMW && !ex_a;
    endsequence

    property p_rmw_diff;
        exec_op == sbd_pkg::SBD_OP_RMW |-> alu_diff == 8'(mem_val - w_r);
    endproperty
    a_rmw_diff: assert property (p_rmw_diff) else $error("diff not f minus w"); // RULE1

    property p_rmw_to_w;
        s_rmw_w |=> w_r == $past(alu_diff) && mem_r[$past(mem_idx)] == $past(mem_val);
    endproperty
    a_rmw_to_w: assert property (p_rmw_to_w) else $error("d=0 result misplaced"); // RULE2

    property p_rmw_to_f;
        s_rmw_f |=> mem_r[$past(mem_idx)] == $past(alu_diff) && $stable(w_r);
    endproperty
    a_rmw_to_f: assert property (p_rmw_to_f) else $error("d=1 result misplaced"); // RULE3

    property p_access;
        s_access_direct and !(ext_r && ex_f <= `SBD_IDX_LIMIT) |->
            eff_addr[11:8] == (ex_f < `SBD_ACC_SPLIT ? `SBD_ACC_LO_BANK : `SBD_ACC_HI_BANK)
            && eff_addr[7:0] == ex_f;
    endproperty
    a_access: assert property (p_access) else $error("access bank mapping wrong"); // RULE4

    property p_banked;
        exec_op == sbd_pkg::SBD_OP_RMW && ex_a |-> eff_addr == {bank_r, ex_f};
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong"); // RULE5

    property p_indexed;
        s_access_direct and ext_r && ex_f <= `SBD_IDX_LIMIT |->
            eff_addr == 12'(idx_r + {4'h0, ex_f});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong"); // RULE6

    property p_lit;
        exec_op == sbd_pkg::SBD_OP_LIT |=> w_r == $past(lit_expect) && flags_r.c == $past(lit_nob);
    endproperty
    a_lit: assert property (p_lit) else $error("literal subtract wrong"); // RULE7

    property p_flags;
        exec_op != sbd_pkg::SBD_OP_NONE |=>
            flags_r.z == ($past(alu_diff) == 8'h00) && flags_r.n == $past(alu_diff[7]);
    endproperty
    a_flags: assert property (p_flags) else $error("flags not from difference"); // RULE8

    property p_one_cycle;
        wr_pend_r |-> hreadyout;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("execute stalled the bus"); // RULE8
endmodule : sbd_top

// *** dv/sbd_top_bench.sv ***
// Purpose: Self-checking bench for the subtract datapath, driven over AHB-Lite.
// Assumes: One slave, so hready is fed back from hreadyout; transfers are not pipelined.
// Notes:   MEM_AW is 12 so that every resolved address has a memory cell of its own.
`timescale 1ns/10ps
`include "sbd_params.svh"
module sbd_top_bench;
    typedef struct packed {
        logic [3:0] bank;
        logic ext;
        logic [11:0] idx;
        logic [11:0] maddr;
        logic [7:0] mval;
        logic [7:0] w;
        logic [15:0] instr;
        logic [7:0] em;
        logic [7:0] ew;
        logic [4:0] ef;
    } sbd_row_t;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hready;
    logic hreadyout;
    logic hresp;
    int error_cnt;
    int n_tests;

    // Each row preloads bank, mode, index base, one memory cell and W, then runs one word
    sbd_row_t rows [15] = '{
        '{4'h0, 1'b0, 12'h000, 12'h000, 8'h00, 8'h01, 16'h0802, 8'h00, 8'h01, 5'h03},
        '{4'h0, 1'b0, 12'h000, 12'h000, 8'h00, 8'h02, 16'h0802, 8'h00, 8'h00, 5'h07},
        '{4'h0, 1'b0, 12'h000, 12'h000, 8'h00, 8'h03, 16'h0802, 8'h00, 8'hff, 5'h10},
        '{4'h0, 1'b0, 12'h000, 12'h000, 8'h00, 8'h01, 16'h0880, 8'h00, 8'h7f, 5'h09},
        '{4'h0, 1'b0, 12'h000, 12'h000, 8'h00, 8'hff, 16'h087f, 8'h00, 8'h80, 5'h1a},
        '{4'h0, 1'b0, 12'h000, 12'h000, 8'h00, 8'h01, 16'h0810, 8'h00, 8'h0f, 5'h01},
        '{4'h3, 1'b0, 12'h000, 12'h325, 8'h50, 8'h20, 16'h5f25, 8'h30, 8'h20, 5'h03},
        '{4'h3, 1'b0, 12'h000, 12'h325, 8'h50, 8'h20, 16'h5d25, 8'h50, 8'h30, 5'h03},
        '{4'h3, 1'b0, 12'h000, 12'h010, 8'h05, 8'h10, 16'h5e10, 8'hf5, 8'h10, 5'h12},
        '{4'h3, 1'b0, 12'h000, 12'hfa0, 8'h00, 8'h01, 16'h5ea0, 8'hff, 8'h01, 5'h10},
        '{4'h3, 1'b1, 12'h200, 12'h205, 8'h09, 8'h09, 16'h5e05, 8'h00, 8'h09, 5'h07},
        '{4'h3, 1'b1, 12'h200, 12'h25f, 8'h80, 8'h01, 16'h5e5f, 8'h7f, 8'h01, 5'h09},
        '{4'h3, 1'b1, 12'h200, 12'hf60, 8'h40, 8'h41, 16'h5e60, 8'hff, 8'h41, 5'h10},
        '{4'h3, 1'b1, 12'hfff, 12'h001, 8'h33, 8'h11, 16'h5e02, 8'h22, 8'h11, 5'h03},
        '{4'h3, 1'b1, 12'h200, 12'h205, 8'h09, 8'h0a, 16'h5c05, 8'h09, 8'hff, 5'h10}
    };

    sbd_top #(.MEM_AW(12)) DUT (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata)
    );

    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait: a slave that never answers ends the run instead of hanging it
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, hready, 1'b1);
            close_out();
        end
    endtask : wait_ready

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        wait_ready();
        chk(hrdata, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask : rchk

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        error_cnt = 0;
        n_tests = 0;
        repeat (8) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        chk(hrdata, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int o = 0; o < 8; o++) begin
            rchk(8'(o * 4), 32'h0);
        end
        foreach (rows[i]) begin
            wr(`SBD_OFF_BANK, {28'h0, rows[i].bank});
            wr(`SBD_OFF_CFG, {31'h0, rows[i].ext});
            wr(`SBD_OFF_IDX, {20'h0, rows[i].idx});
            wr(`SBD_OFF_MADDR, {20'h0, rows[i].maddr});
            wr(`SBD_OFF_MDATA, {24'h0, rows[i].mval});
            wr(`SBD_OFF_WREG, {24'h0, rows[i].w});
            wr(`SBD_OFF_INSTR, {16'h0, rows[i].instr});
            rchk(`SBD_OFF_WREG, {24'h0, rows[i].ew});
            rchk(`SBD_OFF_MDATA, {24'h0, rows[i].em});
            rchk(`SBD_OFF_STATUS, {27'h0, rows[i].ef});
        end
        // A borrow-chained word is stored but must not touch W or the flags
        wr(`SBD_OFF_WREG, 32'hffffff12);
        wr(`SBD_OFF_STATUS, 32'h0000001f);
        wr(`SBD_OFF_INSTR, 32'h00005a12);
        rchk(`SBD_OFF_INSTR, 32'h00005a12);
        rchk(`SBD_OFF_WREG, 32'h00000012);
        rchk(`SBD_OFF_STATUS, 32'h0000001f);
        wr(8'h20, 32'hffffffff);
        rchk(8'h20, 32'h0);
        // Literal form leaves the selected memory cell alone
        wr(`SBD_OFF_INSTR, 32'h00000830);
        rchk(`SBD_OFF_WREG, 32'h0000001e);
        rchk(`SBD_OFF_STATUS, 32'h00000001);
        rchk(`SBD_OFF_MDATA, 32'h00000009);
        // Back-to-back words: the second must see the first one's W
        wr(`SBD_OFF_INSTR, 32'h00000830);
        wr(`SBD_OFF_INSTR, 32'h00000830);
        rchk(`SBD_OFF_WREG, 32'h0000001e);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({31'h0, hreadyout}, 32'h1);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(`SBD_OFF_WREG, 32'h0);
        rchk(`SBD_OFF_STATUS, 32'h0);
        close_out();
    end
endmodule : sbd_top_bench
